// ### src/rsc_pkg.sv
// Purpose: Shared constants and types for the reset and recovery sequencer.
// Assumes: System clock of 25 MHz; times are converted to whole cycles.
// Notes:   Register offsets are byte addresses on the Avalon-MM slave.
package rsc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 25;
  // Oscillator start-up that precedes a recovery count, rounded up.
  localparam int unsigned OSC_START_NS = 4000;
  localparam logic [7:0] OSC_START_CYC =
    8'((OSC_START_NS * CLK_MHZ + 999) / 1000);
  // Least low width on the reset pin accepted while stopped.
  localparam int unsigned STOP_GLITCH_NS = 200;
  localparam logic [3:0] STOP_GLITCH_CYC =
    4'((STOP_GLITCH_NS * CLK_MHZ + 999) / 1000);
  // Synchronised low cycles that trip a reset in normal operation.
  localparam logic [3:0] PIN_MIN_CYC = 4'h3;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] CAUSE_OFS = 4'h0;
  localparam logic [3:0] CTRL_OFS = 4'h4;
  localparam int unsigned DBG_REQ_BIT = 0;
  localparam int unsigned LVD_IE_BIT = 1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {S_RUN, S_STOP, S_HOLD, S_EXTEND} seq_state_t;
  typedef struct packed {
    logic por;
    logic stop;
    logic wdt;
    logic pin_reset_cause_flag;
  } cause_t;
  localparam cause_t CAUSE_POR = 4'h8;
  localparam cause_t CAUSE_EXT = 4'h1;
  localparam cause_t CAUSE_WDT = 4'h2;
  localparam cause_t CAUSE_WAKE_PIN = 4'h4;
  localparam cause_t CAUSE_WAKE_WDT = 4'h6;
endpackage

// ### src/reset_stop_ctrl.sv
// Purpose: Reset sequencing and stop-mode recovery with cause flags.
// Assumes: All inputs synchronous to CLK except RST_PIN_I; OSC_TICK pulses
//          once per internal oscillator cycle; CLK keeps running in stop.
// Notes:   Block reset RESETN stands for the power-on event.
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - Watchdog time-out resets when select option is 1, else interrupt only.
// - Watchdog-caused system reset sets the watchdog cause flag.
// - Reset pin low four cycles always resets; three may.
// - Stay in reset while pin low; leave on first edge after release; the code leaves on the third clock edge after release.
// - Pin-started system reset sets the pin cause flag.
// - Reset pin is open-drain low output during reset or when port asks.
// - Internal reset drives the pin low until the delay count elapses.
// - Debugger request gives power-on-type reset; debug unit keeps state.
// - Debugger request bit self-clears; power-on flag then reads set.
// - Recovery holds processor 66 or 5000 oscillator cycles plus start-up.
// - Recovery keeps all registers but watchdog and oscillator control.
// - After recovery the internal oscillator is enabled and selected.
// - Leaving reset loads the program counter from vector address 0002H.
// - Stop-mode recovery sets the sleep-wake flag.
// - In stop: watchdog or port wake recovers; pin or debug pin resets.
// - Watchdog time-out in stop recovers and sets watchdog and wake flags.
// - Any enabled port pin edge, either direction, starts recovery.
// - Port input capture is off in stop and through the recovery delay.
// - In stop, reset pin pulses shorter than the glitch width are ignored.
// - Low-voltage flag is live, unlatched, and not cleared by access.
// - Enabled low-voltage detection raises an interrupt request.
// - Brownout detector off also disables low-voltage flag and interrupt.
// - Reading the cause register clears its upper four flags.
module reset_stop_ctrl #(
  parameter int unsigned N_PORT = 8,
  parameter int unsigned DLY_SHORT = 66,
  parameter int unsigned DLY_XTAL = 5000
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RST_PIN_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OE,
  input wire logic PORT_DRV_LOW,
  input wire logic WDT_TIMEOUT,
  input wire logic WDT_RESET_SEL,
  input wire logic XTAL_EN,
  input wire logic STOP_ENTER,
  input wire logic DBG_PIN,
  input wire logic OSC_TICK,
  input wire logic [N_PORT-1:0] PORT_IN,
  input wire logic [N_PORT-1:0] PORT_WAKE_EN,
  input wire logic LV_BELOW,
  input wire logic BROWNOUT_EN,
  output logic CPU_RST,
  output logic SYS_RST,
  output logic WAKE_INIT,
  output logic PC_LOAD,
  output logic [15:0] RESET_VECTOR,
  output logic WDT_IRQ,
  output logic LVD_FLAG,
  output logic LVD_IRQ,
  output logic PORT_CAPTURE_EN
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rsc_pkg::seq_state_t st;
    logic ps1;
    logic ps2;
    logic [3:0] low_cnt;
    logic [7:0] up_cnt;
    logic [15:0] osc_cnt;
    logic wake;
    logic drive;
    logic oe;
    logic pin_o;
    logic wdt_pend;
    rsc_pkg::cause_t cause;
    logic dbg_req;
    logic lvd_ie;
    logic [N_PORT-1:0] port_prev;
    logic ws;
    logic [31:0] rdata;
    logic cpu_rst;
    logic sys_rst;
    logic wake_init;
    logic pc_load;
    logic wdt_irq;
    logic low_voltage_flag;
    logic lvd_irq;
    logic cap_en;
    logic [15:0] vec;
  } state_t;

  // Power-on: hold everything in reset and drive the pin from the start.
  localparam state_t RST_Q = '{st: rsc_pkg::S_HOLD, ps1: 1'b1, ps2: 1'b1,
    low_cnt: 4'h0, up_cnt: 8'h00, osc_cnt: 16'h0000, wake: 1'b0,
    drive: 1'b1, oe: 1'b1, pin_o: 1'b0, wdt_pend: 1'b0,
    cause: rsc_pkg::CAUSE_POR, dbg_req: 1'b0, lvd_ie: 1'b0,
    port_prev: '0, ws: 1'b1, rdata: 32'h0000_0000, cpu_rst: 1'b1,
    sys_rst: 1'b1, wake_init: 1'b0, pc_load: 1'b0, wdt_irq: 1'b0,
    low_voltage_flag: 1'b0, lvd_irq: 1'b0, cap_en: 1'b0,
    vec: rsc_pkg::RESET_VECTOR_ADDR};

  state_t q;
  state_t d;
  logic acc;
  logic pin_trip;
  logic port_wake;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Last hold count, one less than the hold in oscillator cycles; the crystal needs the long one.
  function automatic logic [15:0] dly_last(input logic xtal);
    dly_last = xtal ? 16'(DLY_XTAL - 1) : 16'(DLY_SHORT - 1);
  endfunction

  // Start a full system reset with the given cause pattern.
  function automatic state_t go_sys(input state_t s,
                                    input rsc_pkg::cause_t c,
                                    input logic drv);
    state_t r;
    r = s;
    r.st = rsc_pkg::S_HOLD;
    r.wake = 1'b0;
    r.cpu_rst = 1'b1;
    r.sys_rst = 1'b1;
    r.drive = drv;
    r.up_cnt = 8'h00;
    r.osc_cnt = 16'h0000;
    r.dbg_req = 1'b0;
    r.wdt_pend = 1'b0;
    r.cause = c;
    return r;
  endfunction

  // Start a recovery: the processor alone is reset, registers survive.
  function automatic state_t go_wake(input state_t s, input logic wdt,
                                     input logic irq);
    state_t r;
    r = s;
    r.st = rsc_pkg::S_HOLD;
    r.wake = 1'b1;
    r.cpu_rst = 1'b1;
    r.sys_rst = 1'b0;
    r.wake_init = 1'b1;
    r.drive = 1'b0;
    r.up_cnt = rsc_pkg::OSC_START_CYC;
    r.osc_cnt = 16'h0000;
    r.wdt_pend = irq;
    r.cause = wdt ? rsc_pkg::CAUSE_WAKE_WDT : rsc_pkg::CAUSE_WAKE_PIN;
    return r;
  endfunction

  // Release reset and have the processor fetch its vector.
  function automatic state_t leave(input state_t s);
    state_t r;
    r = s;
    r.st = rsc_pkg::S_RUN;
    r.cpu_rst = 1'b0;
    r.sys_rst = 1'b0;
    r.drive = 1'b0;
    r.pc_load = 1'b1;
    r.wdt_irq = s.wdt_pend;
    r.wdt_pend = 1'b0;
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  // Only the second synchroniser flop feeds the width counter.
  assign pin_trip = !q.ps2 && (q.st == rsc_pkg::S_STOP ?
    q.low_cnt >= rsc_pkg::STOP_GLITCH_CYC - 4'h1 :
    q.low_cnt >= rsc_pkg::PIN_MIN_CYC - 4'h1);
  assign port_wake = |((PORT_IN ^ q.port_prev) & PORT_WAKE_EN);
  assign acc = (AVS_READ || AVS_WRITE) && !q.ws;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // One comb process so flag set/clear priority is visible in one place.
  always_comb begin
    d = q;
    d.ps1 = RST_PIN_I;
    d.ps2 = q.ps1;
    d.port_prev = PORT_IN;
    d.wake_init = 1'b0;
    d.pc_load = 1'b0;
    d.wdt_irq = 1'b0;
    d.pin_o = 1'b0;
    d.vec = rsc_pkg::RESET_VECTOR_ADDR;
    // Shared detector circuitry: no brownout detector, no flag.
    d.low_voltage_flag = LV_BELOW && BROWNOUT_EN;
    // Waitrequest drops one cycle after a request; access then ends.
    d.ws = !((AVS_READ || AVS_WRITE) && q.ws);
    // Read data is taken when the request is first seen, so that it
    // already stands in the cycle in which waitrequest is low.
    if (AVS_READ && q.ws) begin
      case (AVS_ADDRESS)
        rsc_pkg::CAUSE_OFS: d.rdata = {24'h00_0000, q.cause, 3'h0, q.low_voltage_flag};
        rsc_pkg::CTRL_OFS: d.rdata = {30'h0, q.lvd_ie, q.dbg_req};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // Only the flags that were reported are cleared; a newer one stays.
    if (acc && AVS_READ && AVS_ADDRESS == rsc_pkg::CAUSE_OFS) begin
      d.cause = rsc_pkg::cause_t'(q.cause & ~q.rdata[7:4]);
    end
    if (acc && AVS_WRITE && AVS_ADDRESS == rsc_pkg::CTRL_OFS) begin
      d.dbg_req = AVS_WRITEDATA[rsc_pkg::DBG_REQ_BIT];
      d.lvd_ie = AVS_WRITEDATA[rsc_pkg::LVD_IE_BIT];
    end
    d.lvd_irq = d.low_voltage_flag && d.lvd_ie;
    // Width counter runs only where the pin can start a reset.
    if ((q.st == rsc_pkg::S_RUN || q.st == rsc_pkg::S_STOP) && !q.ps2) begin
      d.low_cnt = (q.low_cnt == 4'hF) ? q.low_cnt : q.low_cnt + 4'h1;
    end else begin
      d.low_cnt = 4'h0;
    end
    // Events below overwrite the read clear, so a set always wins.
    case (q.st)
      rsc_pkg::S_RUN: begin
        if (pin_trip) begin
          d = go_sys(d, rsc_pkg::CAUSE_EXT, 1'b0);
        end else if (WDT_TIMEOUT && WDT_RESET_SEL) begin
          d = go_sys(d, rsc_pkg::CAUSE_WDT, 1'b1);
        end else if (q.dbg_req) begin
          d = go_sys(d, rsc_pkg::CAUSE_POR, 1'b1);
        end else begin
          d.wdt_irq = WDT_TIMEOUT;
          if (STOP_ENTER) begin
            d.st = rsc_pkg::S_STOP;
          end
        end
      end
      rsc_pkg::S_STOP: begin
        if (pin_trip) begin
          d = go_sys(d, rsc_pkg::CAUSE_EXT, 1'b0);
        end else if (!DBG_PIN) begin
          d = go_sys(d, rsc_pkg::CAUSE_POR, 1'b1);
        end else if (WDT_TIMEOUT) begin
          d = go_wake(d, 1'b1, !WDT_RESET_SEL);
        end else if (port_wake) begin
          d = go_wake(d, 1'b0, 1'b0);
        end
      end
      rsc_pkg::S_HOLD: begin
        // Start-up wait first, then count oscillator cycles.
        if (q.up_cnt != 8'h00) begin
          d.up_cnt = q.up_cnt - 8'h01;
        end else if (OSC_TICK) begin
          if (q.osc_cnt == dly_last(XTAL_EN)) begin
            // A pin still held low by someone else extends the reset.
            if (!q.wake && !q.drive && !q.ps2) begin
              d.st = rsc_pkg::S_EXTEND;
            end else begin
              d = leave(d);
            end
          end else begin
            d.osc_cnt = q.osc_cnt + 16'h0001;
          end
        end
      end
      rsc_pkg::S_EXTEND: begin
        if (q.ps2) begin
          d = leave(d);
        end
      end
      default: d.st = rsc_pkg::S_HOLD;
    endcase
    d.oe = d.drive || PORT_DRV_LOW;
    d.cap_en = d.st == rsc_pkg::S_RUN && !d.cpu_rst;
  end

  // Debug unit is reset by RESETN only, never by SYS_RST.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      q <= RST_Q;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign AVS_READDATA = q.rdata;
  assign AVS_WAITREQUEST = q.ws;
  assign RST_PIN_O = q.pin_o;
  assign RST_PIN_OE = q.oe;
  assign CPU_RST = q.cpu_rst;
  assign SYS_RST = q.sys_rst;
  assign WAKE_INIT = q.wake_init;
  assign PC_LOAD = q.pc_load;
  assign RESET_VECTOR = q.vec;
  assign WDT_IRQ = q.wdt_irq;
  assign LVD_FLAG = q.low_voltage_flag;
  assign LVD_IRQ = q.lvd_irq;
  assign PORT_CAPTURE_EN = q.cap_en;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  AST_WDT_IRQ_ONLY: assert property (
    q.st == rsc_pkg::S_RUN && WDT_TIMEOUT && !WDT_RESET_SEL && !pin_trip
    && !q.dbg_req |=> WDT_IRQ && !CPU_RST)
    else $error("Watchdog interrupt mode reset the processor.");
  AST_WDT_RESET: assert property (
    q.st == rsc_pkg::S_RUN && WDT_TIMEOUT && WDT_RESET_SEL && !pin_trip
    |=> CPU_RST && SYS_RST && q.cause == rsc_pkg::CAUSE_WDT)
    else $error("Watchdog reset missing or wrong cause.");
  AST_PIN_WIDTH: assert property (
    (q.st == rsc_pkg::S_RUN && !q.ps2) [*3] |=> CPU_RST)
    else $error("Pin held low three synced cycles did not reset.");
  AST_PIN_HOLD: assert property (
    q.st == rsc_pkg::S_EXTEND && !q.ps2
    |=> CPU_RST && q.st == rsc_pkg::S_EXTEND)
    else $error("Left reset while the pin was still low.");
  AST_PIN_CAUSE: assert property (
    q.st == rsc_pkg::S_RUN && pin_trip
    |=> q.cause == rsc_pkg::CAUSE_EXT && SYS_RST)
    else $error("Pin reset did not set the pin cause flag.");
  AST_PIN_DRIVE: assert property (
    $rose(CPU_RST) && SYS_RST && !q.cause.pin_reset_cause_flag |-> RST_PIN_OE && !RST_PIN_O)
    else $error("Internal reset did not drive the pin low.");
  AST_DBG_RESET: assert property (
    q.st == rsc_pkg::S_RUN && q.dbg_req && !pin_trip
    && !(WDT_TIMEOUT && WDT_RESET_SEL)
    |=> CPU_RST && !q.dbg_req && q.cause == rsc_pkg::CAUSE_POR)
    else $error("Debugger reset request mishandled.");
  AST_WAKE_LEN: assert property (
    WAKE_INIT |-> CPU_RST [*8])
    else $error("Recovery hold ended too early.");
  AST_WAKE_KEEP: assert property (
    WAKE_INIT |-> !SYS_RST ##1 !SYS_RST)
    else $error("Recovery reset the control registers.");
  AST_WAKE_WDT: assert property (
    q.st == rsc_pkg::S_STOP && WDT_TIMEOUT && !pin_trip && DBG_PIN
    |=> WAKE_INIT && q.cause == rsc_pkg::CAUSE_WAKE_WDT)
    else $error("Watchdog wake did not set both flags.");
  AST_WAKE_PIN: assert property (
    q.st == rsc_pkg::S_STOP && port_wake && !WDT_TIMEOUT && !pin_trip
    && DBG_PIN |=> WAKE_INIT && q.cause == rsc_pkg::CAUSE_WAKE_PIN)
    else $error("Port edge did not start recovery.");
  AST_STOP_GLITCH: assert property (
    q.st == rsc_pkg::S_STOP && !pin_trip && DBG_PIN && !WDT_TIMEOUT
    && !port_wake |=> !CPU_RST)
    else $error("Short stop-mode pin pulse caused a reset.");
  AST_VECTOR: assert property (
    $fell(CPU_RST) |-> PC_LOAD && RESET_VECTOR == rsc_pkg::RESET_VECTOR_ADDR)
    else $error("Reset release without vector load.");
  AST_NO_CAPTURE: assert property (
    CPU_RST || q.st == rsc_pkg::S_STOP |-> !PORT_CAPTURE_EN)
    else $error("Port capture enabled in stop or reset.");
  AST_LVD_LIVE: assert property (
    ##1 LVD_FLAG == $past(LV_BELOW && BROWNOUT_EN))
    else $error("Low-voltage flag does not follow the supply.");
  AST_LVD_IRQ: assert property (
    LVD_IRQ |-> LVD_FLAG && BROWNOUT_EN || $past(BROWNOUT_EN))
    else $error("Low-voltage interrupt without the flag.");
  AST_READ_CLR: assert property (
    acc && AVS_READ && AVS_ADDRESS == rsc_pkg::CAUSE_OFS
    && q.st == rsc_pkg::S_RUN && !pin_trip && !WDT_TIMEOUT && !q.dbg_req
    |=> q.cause == 4'h0)
    else $error("Cause read did not clear the flags.");

  COV_PIN_RESET: cover property (
    q.st == rsc_pkg::S_RUN && pin_trip);
  COV_EXTEND: cover property (
    q.st == rsc_pkg::S_EXTEND ##1 q.st == rsc_pkg::S_RUN);
  COV_PORT_WAKE: cover property (
    q.st == rsc_pkg::S_STOP && port_wake ##1 WAKE_INIT);
  COV_DBG_RESET: cover property (
    q.st == rsc_pkg::S_RUN && q.dbg_req ##1 CPU_RST);
endmodule // reset_stop_ctrl

// ### sim/rst_line_model.sv
// Purpose: Board side of the open-drain reset line, with its pull-up.
// Assumes: The bench asks for low pulses through the pulse task.
// Notes:   A released line rises to the pull-up level, never holds.
`timescale 1ns/1ns
module rst_line_model (
  input wire logic CLK,
  input wire logic DEV_O,
  input wire logic DEV_OE,
  output logic LINE
);
  logic ext_low;

  initial begin
    ext_low = 1'b0;
  end

  // ---------------------------------------------------------------
  // Wire level
  // ---------------------------------------------------------------
  // Either party pulling low wins; otherwise the pull-up holds it high.
  assign LINE = ((DEV_OE && !DEV_O) || ext_low) ? 1'b0 : 1'b1;

  // Pull the line low for n whole clock cycles, edge aligned.
  task automatic pulse(input int n);
    ext_low <= 1'b1;
    repeat (n) @(posedge CLK);
    ext_low <= 1'b0;
  endtask
endmodule // rst_line_model

// ### sim/reset_stop_ctrl_bench.sv
// Purpose: Self-checking bench for the reset and recovery sequencer.
// Assumes: OSC_TICK runs every cycle, so hold counts are clock cycles.
// Notes:   Short hold counts keep the run brief; start-up stays 100.
`timescale 1ns/1ns
module reset_stop_ctrl_bench;
  localparam int unsigned SHORT = 6;
  localparam int unsigned XTAL = 20;
  logic clk, resetn, rd, wr, drv_low, wdt_to, wdt_sel, xtal_en;
  logic stop_in, dbg_pin, tick, lv_below, bo_en;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, q;
  logic wait_req, pin_o, pin_oe, pin_line, cpu_rst, sys_rst, wake_init;
  logic pc_load, wdt_irq, lvd_flag, lvd_irq, cap_en;
  logic [7:0] port_in, port_en;
  logic [15:0] vec;
  int fails, check_count, cycles, n;

  reset_stop_ctrl #(.N_PORT(8), .DLY_SHORT(SHORT), .DLY_XTAL(XTAL))
  reset_stop_ctrl_inst (.CLK(clk), .RESETN(resetn), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .RST_PIN_I(pin_line), .RST_PIN_O(pin_o), .RST_PIN_OE(pin_oe),
    .PORT_DRV_LOW(drv_low), .WDT_TIMEOUT(wdt_to), .WDT_RESET_SEL(wdt_sel),
    .XTAL_EN(xtal_en), .STOP_ENTER(stop_in), .DBG_PIN(dbg_pin),
    .OSC_TICK(tick), .PORT_IN(port_in), .PORT_WAKE_EN(port_en),
    .LV_BELOW(lv_below), .BROWNOUT_EN(bo_en), .CPU_RST(cpu_rst),
    .SYS_RST(sys_rst), .WAKE_INIT(wake_init), .PC_LOAD(pc_load),
    .RESET_VECTOR(vec), .WDT_IRQ(wdt_irq), .LVD_FLAG(lvd_flag),
    .LVD_IRQ(lvd_irq), .PORT_CAPTURE_EN(cap_en));

  rst_line_model rst_line_model_inst (.CLK(clk), .DEV_O(pin_o),
    .DEV_OE(pin_oe), .LINE(pin_line));

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // A hung wait would stall forever, so a ceiling ends the run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One Avalon access; the request holds until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (wait_req !== 1'b0) begin
      @(posedge clk);
    end
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Wait until the processor reset rises.
  task automatic wait_rst();
    while (cpu_rst !== 1'b1) begin
      @(posedge clk);
    end
  endtask

  // Count cycles until the processor leaves reset.
  task automatic wait_run(output int k);
    k = 0;
    while (cpu_rst !== 1'b0) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic pulse_in(input int which);
    if (which == 0) wdt_to <= 1'b1;
    else stop_in <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    stop_in <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_power();
    cyc(2);
    chk("pin_oe", 1, pin_oe);
    chk("pin_line", 0, pin_line);
    chk("pin_o", 0, pin_o);
    chk("cap_en", 0, cap_en);
    wait_run(n);
    chk("pc_load", 1, pc_load);
    chk("vector", 32'h0000_0002, vec);
    chk("cap_en", 1, cap_en);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0080, q);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0000, q);
    bus(0, 4'h8, 0, q);
    chk("unmapped", 32'h0000_0000, q);
  endtask

  task automatic t_pin();
    rst_line_model_inst.pulse(4);
    cyc(4);
    chk("cpu_rst", 1, cpu_rst);
    wait_run(n);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0010, q);
    fork
      rst_line_model_inst.pulse(40);
      begin
        cyc(30);
        chk("cpu_rst", 1, cpu_rst);
      end
    join
    wait_run(n);
    chk("release", 1, n <= 5);
  endtask

  task automatic t_wdt();
    wdt_sel <= 1'b1;
    xtal_en <= 1'b1;
    pulse_in(0);
    @(posedge clk);
    chk("sys_rst", 1, sys_rst);
    chk("pin_oe", 1, pin_oe);
    wait_run(n);
    chk("xtal_hold", 1, n >= XTAL - 1 && n <= XTAL + 4);
    xtal_en <= 1'b0;
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0020, q);
    wdt_sel <= 1'b0;
    pulse_in(0);
    @(posedge clk);
    chk("wdt_irq", 1, wdt_irq);
    chk("cpu_rst", 0, cpu_rst);
    bus(0, 4'h0, 0, q);
  endtask

  task automatic t_dbg();
    bus(1, 4'h4, 32'h0000_0001, q);
    wait_rst();
    chk("sys_rst", 1, sys_rst);
    wait_run(n);
    bus(0, 4'h4, 0, q);
    chk("ctrl", 0, q[0]);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0080, q);
  endtask

  task automatic t_stop_port();
    port_en <= 8'h04;
    pulse_in(1);
    cyc(3);
    chk("cap_en", 0, cap_en);
    port_in <= 8'h04;
    wait_rst();
    chk("wake_init", 1, wake_init);
    chk("sys_rst", 0, sys_rst);
    wait_run(n);
    chk("wake_hold", 1, n >= 99 + SHORT && n <= 104 + SHORT);
    chk("pc_load", 1, pc_load);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0040, q);
  endtask

  task automatic t_stop_wdt();
    pulse_in(1);
    cyc(3);
    pulse_in(0);
    wait_rst();
    chk("sys_rst", 0, sys_rst);
    wait_run(n);
    chk("wdt_irq", 1, wdt_irq);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0060, q);
  endtask

  task automatic t_stop_pin();
    pulse_in(1);
    cyc(3);
    rst_line_model_inst.pulse(3);
    cyc(8);
    chk("cpu_rst", 0, cpu_rst);
    dbg_pin <= 1'b0;
    wait_rst();
    chk("sys_rst", 1, sys_rst);
    dbg_pin <= 1'b1;
    wait_run(n);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0080, q);
    pulse_in(1);
    cyc(3);
    rst_line_model_inst.pulse(8);
    wait_rst();
    wait_run(n);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0010, q);
  endtask

  task automatic t_lvd();
    lv_below <= 1'b1;
    cyc(3);
    chk("lvd_flag", 1, lvd_flag);
    bus(0, 4'h0, 0, q);
    bus(0, 4'h0, 0, q);
    chk("cause", 32'h0000_0001, q);
    chk("lvd_irq", 0, lvd_irq);
    bus(1, 4'h4, 32'h0000_0002, q);
    cyc(2);
    chk("lvd_irq", 1, lvd_irq);
    bo_en <= 1'b0;
    cyc(3);
    chk("lvd_flag", 0, lvd_flag);
    chk("lvd_irq", 0, lvd_irq);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Inputs start idle; reset is held for 20 cycles, then each scenario.
  initial begin
    {resetn, rd, wr, drv_low, wdt_to, wdt_sel, xtal_en, stop_in} = '0;
    {dbg_pin, tick, bo_en} = 3'b111;
    lv_below = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    port_in = 8'h00;
    port_en = 8'h00;
    fails = 0;
    check_count = 0;
    cycles = 0;
    cyc(20);
    resetn <= 1'b1;
    t_power();
    t_pin();
    t_wdt();
    t_dbg();
    t_stop_port();
    t_stop_wdt();
    t_stop_pin();
    t_lvd();
    print_verdict();
  end
endmodule // reset_stop_ctrl_bench
